// >>> logic/lics_top.sv
// Impedance register bank with indirect offset/data access and code select
module lics_top
  import lics_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic first_revision,
  input wire logic immediate_update_enable,
  input wire logic link_disconnect,
  input wire logic offset_wr,
  input wire logic indirect_write_select,
  input wire logic [9:0] indirect_register_number,
  input wire logic data_wr,
  input wire logic [31:0] data_wdata,
  input wire logic [4:0] drive_calibrated_value,
  input wire logic [4:0] termination_calibrated_value,
  output logic indirect_access_done,
  output logic [31:0] data_rdata,
  output lics_pkg::lics_phy_type phy_low,
  output lics_pkg::lics_phy_type phy_high
);
  import lics_pkg::*;

  localparam logic [6:0] APPLY_LAST = 7'(LICS_APPLY_CYCLES - 1);
  localparam logic [1:0] ACCESS_LAST = 2'(LICS_ACCESS_CYCLES - 1);

  logic [31:0] data_hold;
  logic pend_write;
  logic [9:0] pend_number;
  logic [1:0] access_cnt;
  logic busy;
  lics_group_type grp [2];
  lics_group_type staged [2];
  logic [1:0] stage_pending;
  logic [6:0] apply_cnt [2];
  logic [2:0] rev_first_q;
  logic [1:0] disc_sync;
  logic disc_seen;
  logic rst_hold;
  logic rst_done;

  ////////////////////////////////////////////////////////////////////////
  // Strap-like revision pin passes three stages; never loaded by reset
  // Only the last two stages are compared, so a late strap is never half-seen
  always_ff @(posedge mclk)
  begin
    rev_first_q <= {rev_first_q[1:0], first_revision};
  end

  // Disconnect comes from link logic in another domain; three stages
  logic disc_meta;
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      disc_meta <= 1'b0;
      disc_sync <= 2'b00;
    end
    else
    begin
      disc_meta <= link_disconnect;
      disc_sync <= {disc_sync[0], disc_meta};
    end
  end
  // Counts only when the last two stages agree high
  assign disc_seen = disc_sync[0] & disc_sync[1];

  ////////////////////////////////////////////////////////////////////////
  // Data port holds full 32-bit word; no byte writes
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      data_hold <= 32'h00000000;
    else if (data_wr && !busy)
      data_hold <= data_wdata;
  end

  // Indirect access sequencer; a new offset write while busy is ignored
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      busy <= 1'b0;
      access_cnt <= 2'h0;
      pend_write <= 1'b0;
      pend_number <= 10'h000;
      indirect_access_done <= 1'b1;
    end
    else if (offset_wr && !busy)
    begin
      busy <= 1'b1;
      access_cnt <= 2'h0;
      pend_write <= indirect_write_select;
      pend_number <= indirect_register_number;
      indirect_access_done <= 1'b0;
    end
    else if (busy)
    begin
      access_cnt <= access_cnt + 2'h1;
      if (access_cnt == ACCESS_LAST)
      begin
        busy <= 1'b0;
        indirect_access_done <= 1'b1;
      end
    end
  end

  logic access_fire;
  assign access_fire = busy && (access_cnt == ACCESS_LAST);

  // Read data with reserved bits zero
  function automatic logic [31:0] pack_reg(input lics_group_type g);
    logic [31:0] r;
    r = 32'h00000000;
    r[LICS_TERM_SEL_LSB +: 3] = g.term_sel;
    r[LICS_TERM_IDX_LSB +: 5] = g.term_idx;
    r[LICS_DRIVE_SEL_LSB +: 3] = g.drive_sel;
    r[LICS_DRIVE_IDX_LSB +: 5] = g.drive_idx;
    return r;
  endfunction

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      data_rdata <= 32'h00000000;
    else if (access_fire && !pend_write)
    begin
      if (pend_number == LICS_REG_LOW_LANES)
        data_rdata <= pack_reg(grp[0]);
      else if (pend_number == LICS_REG_HIGH_LANES)
        data_rdata <= pack_reg(grp[1]);
      else
        data_rdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Code computation shared by drive and termination
  function automatic logic [4:0] eff_code(input logic [2:0] sel, input logic [4:0] cal,
                                          input logic [4:0] idx);
    logic [5:0] sum;
    sum = {1'b0, cal} + {1'b0, idx};
    unique case (sel)
      LICS_SEL_CAL: eff_code = cal;
      LICS_SEL_INDEX: eff_code = idx;
      LICS_SEL_DIFF: eff_code = (idx > cal) ? LICS_CODE_MIN : 5'(cal - idx);
      LICS_SEL_SUM: eff_code = sum[5] ? LICS_CODE_MAX : sum[4:0];
      // Reserved codes fall back to calibrated; software must not use them
      default: eff_code = cal;
    endcase
  endfunction

  // Two lane groups: index 0 low lanes, index 1 high lanes
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_group
      localparam logic [9:0] MY_NUM = (gi == 0) ? LICS_REG_LOW_LANES : LICS_REG_HIGH_LANES;
      logic hit;
      logic [31:0] w;
      lics_phy_type next_phy;
      logic [4:0] rst_idx;
      assign hit = access_fire && pend_write && (pend_number == MY_NUM);
      assign w = data_hold & LICS_WRITABLE_MASK;
      assign rst_idx = rev_first_q[2] ? LICS_IDX_RESET_FIRST_REV : LICS_IDX_RESET_LATER_REV;

      // Software-visible settings; index reset value depends on revision
      always_ff @(posedge mclk)
      begin
        if (!nrst)
        begin
          grp[gi].term_sel <= LICS_SEL_RESET;
          grp[gi].drive_sel <= LICS_SEL_RESET;
          grp[gi].term_idx <= LICS_IDX_RESET_LATER_REV;
          grp[gi].drive_idx <= LICS_IDX_RESET_LATER_REV;
        end
        else if (hit)
        begin
          grp[gi].term_sel <= w[LICS_TERM_SEL_LSB +: 3];
          grp[gi].term_idx <= w[LICS_TERM_IDX_LSB +: 5];
          grp[gi].drive_sel <= w[LICS_DRIVE_SEL_LSB +: 3];
          grp[gi].drive_idx <= w[LICS_DRIVE_IDX_LSB +: 5];
        end
        else if (rst_hold)
        begin
          // Revision strap settles after release; load index reset value then
          grp[gi].term_idx <= rst_idx;
          grp[gi].drive_idx <= rst_idx;
        end
      end

      // Staged copy that the phy actually sees; delayed per update policy
      always_ff @(posedge mclk)
      begin
        if (!nrst)
        begin
          staged[gi] <= '0;
          stage_pending[gi] <= 1'b0;
          apply_cnt[gi] <= 7'h00;
        end
        else if (hit || rst_hold)
        begin
          stage_pending[gi] <= 1'b1;
          apply_cnt[gi] <= 7'h00;
        end
        else if (stage_pending[gi])
        begin
          if (immediate_update_enable ? (apply_cnt[gi] == APPLY_LAST) : disc_seen)
          begin
            staged[gi] <= grp[gi];
            stage_pending[gi] <= 1'b0;
          end
          else if (apply_cnt[gi] != APPLY_LAST)
            apply_cnt[gi] <= apply_cnt[gi] + 7'h01;
        end
      end

      // Effective codes; larger code means lower resistance at the phy
      always_comb
      begin
        next_phy = '0;
        next_phy.drive_code = eff_code(staged[gi].drive_sel, drive_calibrated_value,
                                       staged[gi].drive_idx);
        next_phy.term_code = eff_code(staged[gi].term_sel, termination_calibrated_value,
                                      staged[gi].term_idx);
        next_phy.drive_base_en = 1'b1;
        next_phy.term_base_en = 1'b1;
        if (staged[gi].drive_sel == LICS_SEL_TAP)
        begin
          next_phy.drive_code = LICS_CODE_MIN;
          next_phy.drive_base_en = 1'b0;
          next_phy.drive_tap[staged[gi].drive_idx] = 1'b1;
        end
        if (staged[gi].term_sel == LICS_SEL_TAP)
        begin
          next_phy.term_code = LICS_CODE_MIN;
          next_phy.term_base_en = 1'b0;
          next_phy.term_tap[staged[gi].term_idx] = 1'b1;
        end
      end
    end
  endgenerate

  // One-cycle flag after reset release to load revision-dependent index
  // Waits for a settled strap; a write landing in the same cycle wins and the index load is skipped
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      rst_done <= 1'b0;
    else if (rst_hold)
      rst_done <= 1'b1;
  end
  assign rst_hold = nrst && !rst_done && (rev_first_q[2] == rev_first_q[1]);

  ////////////////////////////////////////////////////////////////////////
  // Lane group outputs registered
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      phy_low <= '0;
      phy_high <= '0;
    end
    else
    begin
      phy_low <= g_group[0].next_phy;
      phy_high <= g_group[1].next_phy;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Done returns within the fixed access latency
  AST_DONE_LATENCY: assert property (@(posedge mclk) disable iff (!nrst)
    (offset_wr && !busy) |=> !indirect_access_done ##2 indirect_access_done)
    else $error("done flag not back after access latency");

  AST_DRIVE_SEL_ZERO: assert property (@(posedge mclk)
    !nrst |=> grp[0].drive_sel == 3'h0 && grp[1].drive_sel == 3'h0)
    else $error("drive select not zero after reset");

  AST_SUM_CLAMP: assert property (@(posedge mclk) disable iff (!nrst)
    (staged[0].drive_sel == 3'b011 && {1'b0, drive_calibrated_value}
      + {1'b0, staged[0].drive_idx} > 6'h1F) |=> phy_low.drive_code == 5'h1F)
    else $error("sum not clamped");

  AST_DIFF_FLOOR: assert property (@(posedge mclk) disable iff (!nrst)
    (staged[0].drive_sel == 3'b010 && staged[0].drive_idx > drive_calibrated_value)
      |=> phy_low.drive_code == 5'h00)
    else $error("difference not floored");

  AST_TAP_BASE_OFF: assert property (@(posedge mclk) disable iff (!nrst)
    staged[1].drive_sel == 3'b100 |=> !phy_high.drive_base_en && $onehot(phy_high.drive_tap))
    else $error("tap mode base resistor on");

  AST_TERM_TAP: assert property (@(posedge mclk) disable iff (!nrst)
    staged[0].term_sel == 3'b100 |=> !phy_low.term_base_en)
    else $error("termination tap base on");

  AST_INDEX_MODE: assert property (@(posedge mclk) disable iff (!nrst)
    staged[1].drive_sel == 3'b001 |=> phy_high.drive_code == $past(staged[1].drive_idx))
    else $error("index mode code wrong");

  // A later write restarts the wait, so it also ends this attempt
  AST_APPLY_BOUND: assert property (@(posedge mclk) disable iff (!nrst)
    (immediate_update_enable && g_group[0].hit)
      ##1 (immediate_update_enable && !g_group[0].hit) [*8]
      |-> ##[0:100] (!stage_pending[0] || !immediate_update_enable || g_group[0].hit))
    else $error("update not applied in time");

  AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (!nrst)
    indirect_access_done |-> data_rdata[28:21] == 8'h00 && data_rdata[12:5] == 8'h00)
    else $error("reserved bits nonzero");

  // Termination follows the same clamped sum as drive
  AST_TERM_SUM_CLAMP: assert property (@(posedge mclk) disable iff (!nrst)
    (staged[0].term_sel == 3'b011 && {1'b0, termination_calibrated_value}
      + {1'b0, staged[0].term_idx} > 6'h1F) |=> phy_low.term_code == 5'h1F)
    else $error("termination sum not clamped");

  // Index fields take the revision value once the strap has settled
  AST_REV_INDEX: assert property (@(posedge mclk) disable iff (!nrst)
    rst_hold |=> grp[0].drive_idx == ($past(rev_first_q[2]) ? LICS_IDX_RESET_FIRST_REV
      : LICS_IDX_RESET_LATER_REV) && grp[1].term_idx == grp[0].drive_idx)
    else $error("index reset value wrong");

endmodule

// >>> logic/lics_pkg.sv
// Constants and carrier types for the link impedance code select block
package lics_pkg;

  // Register numbers on the indirect port
  localparam logic [9:0] LICS_REG_LOW_LANES = 10'h0C0;
  localparam logic [9:0] LICS_REG_HIGH_LANES = 10'h0D0;

  // Field positions
  localparam int LICS_TERM_SEL_LSB = 29;
  localparam int LICS_TERM_IDX_LSB = 16;
  localparam int LICS_DRIVE_SEL_LSB = 13;
  localparam int LICS_DRIVE_IDX_LSB = 0;
  localparam logic [31:0] LICS_WRITABLE_MASK = 32'hE01FE01F;

  // Values after cold reset
  localparam logic [2:0] LICS_SEL_RESET = 3'h0;
  localparam logic [4:0] LICS_IDX_RESET_FIRST_REV = 5'h1F;
  localparam logic [4:0] LICS_IDX_RESET_LATER_REV = 5'h00;

  // Code limits
  localparam logic [4:0] LICS_CODE_MAX = 5'h1F;
  localparam logic [4:0] LICS_CODE_MIN = 5'h00;

  // Update delay toward the physical layer
  localparam int LICS_CLK_MHZ = 50;
  localparam int LICS_APPLY_DELAY_US = 2;
  localparam int LICS_APPLY_CYCLES = LICS_APPLY_DELAY_US * LICS_CLK_MHZ;
  localparam int LICS_ACCESS_CYCLES = 2;

  // Selection modes, shared by drive and termination
  typedef enum logic [2:0] {
    LICS_SEL_CAL = 3'b000,
    LICS_SEL_INDEX = 3'b001,
    LICS_SEL_DIFF = 3'b010,
    LICS_SEL_SUM = 3'b011,
    LICS_SEL_TAP = 3'b100
  } lics_sel_type;

  // Settings for one lane group
  typedef struct packed {
    logic [2:0] term_sel;
    logic [4:0] term_idx;
    logic [2:0] drive_sel;
    logic [4:0] drive_idx;
  } lics_group_type;

  // What one lane group drives into the physical layer
  typedef struct packed {
    logic [4:0] drive_code;
    logic [31:0] drive_tap;
    logic drive_base_en;
    logic [4:0] term_code;
    logic [31:0] term_tap;
    logic term_base_en;
  } lics_phy_type;

endpackage

// >>> dv/test_lics_top.sv
// Self-checking bench for the link impedance code select block
module test_lics_top;
  timeunit 1ns;
  timeprecision 100ps;
  import lics_pkg::*;

  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic first_revision = 1'b1;
  logic immediate_update_enable = 1'b1;
  logic link_disconnect = 1'b0;
  logic offset_wr = 1'b0;
  logic indirect_write_select = 1'b0;
  logic [9:0] indirect_register_number = 10'h000;
  logic data_wr = 1'b0;
  logic [31:0] data_wdata = 32'h00000000;
  logic [4:0] drive_calibrated_value = 5'h14;
  logic [4:0] termination_calibrated_value = 5'h0A;
  logic indirect_access_done;
  logic [31:0] data_rdata;
  lics_phy_type phy_low;
  lics_phy_type phy_high;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] rd;

  lics_top i_lics_top (
    .mclk(mclk),
    .nrst(nrst),
    .first_revision(first_revision),
    .immediate_update_enable(immediate_update_enable),
    .link_disconnect(link_disconnect),
    .offset_wr(offset_wr),
    .indirect_write_select(indirect_write_select),
    .indirect_register_number(indirect_register_number),
    .data_wr(data_wr),
    .data_wdata(data_wdata),
    .drive_calibrated_value(drive_calibrated_value),
    .termination_calibrated_value(termination_calibrated_value),
    .indirect_access_done(indirect_access_done),
    .data_rdata(data_rdata),
    .phy_low(phy_low),
    .phy_high(phy_high)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the whole run needs about 1440 cycles
  always #10 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      miscompares++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic results();
    if (miscompares == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Index values only land a few cycles after release
  task automatic do_reset(input logic rev);
    @(posedge mclk);
    #1 nrst = 1'b0;
    first_revision = rev;
    repeat (12) @(posedge mclk);
    #1 nrst = 1'b1;
    repeat (10) @(posedge mclk);
  endtask

  // Data word goes first, then the number with the write select
  task automatic access(input logic wr, input logic [9:0] num, input logic [31:0] d,
                        output logic [31:0] q);
    int n;
    n = 0;
    if (wr)
    begin
      @(posedge mclk);
      #1 data_wr = 1'b1;
      data_wdata = d;
    end
    @(posedge mclk);
    #1 data_wr = 1'b0;
    offset_wr = 1'b1;
    indirect_write_select = wr;
    indirect_register_number = num;
    @(posedge mclk);
    #1 offset_wr = 1'b0;
    @(posedge mclk);
    #1;
    check("done busy", indirect_access_done, 1'b0);
    while (indirect_access_done !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("done end", indirect_access_done, 1'b1);
    q = data_rdata;
  endtask

  function automatic logic [4:0] code(input logic [2:0] s, input logic [4:0] cal, idx);
    logic [5:0] t;
    t = {1'b0, cal} + {1'b0, idx};
    case (s)
      3'b000: code = cal;
      3'b001: code = idx;
      3'b010: code = (idx > cal) ? 5'h00 : cal - idx;
      3'b011: code = t[5] ? 5'h1F : t[4:0];
      default: code = 5'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic reset_values(input logic [31:0] exp);
    access(1'b0, LICS_REG_LOW_LANES, 32'h0, rd);
    check("low reset", rd, exp);
    access(1'b0, LICS_REG_HIGH_LANES, 32'h0, rd);
    check("high reset", rd, exp);
  endtask

  // Both selects share a mode so one write covers drive and termination
  task automatic phy_case(input logic [9:0] num, input logic [2:0] s, input logic [4:0] di, ti);
    lics_phy_type p;
    logic [31:0] w;
    w = {s, 8'h00, ti, s, 8'h00, di};
    access(1'b1, num, w, rd);
    access(1'b0, num, 32'h0, rd);
    check("readback", rd, w);
    repeat (110) @(posedge mclk);
    #1;
    p = (num == LICS_REG_LOW_LANES) ? phy_low : phy_high;
    check("drive code", p.drive_code, code(s, drive_calibrated_value, di));
    check("term code", p.term_code, code(s, termination_calibrated_value, ti));
    check("drive base", p.drive_base_en, s != LICS_SEL_TAP);
    check("term base", p.term_base_en, s != LICS_SEL_TAP);
    if (s == LICS_SEL_TAP)
    begin
      check("drive tap", p.drive_tap, 32'h1 << di);
      check("term tap", p.term_tap, 32'h1 << ti);
    end
  endtask

  task automatic mode_table();
    logic [2:0] sel [7] = '{3'b000, 3'b001, 3'b010, 3'b010, 3'b011, 3'b011, 3'b100};
    logic [4:0] di [7] = '{5'h03, 5'h07, 5'h05, 5'h18, 5'h0F, 5'h02, 5'h03};
    logic [4:0] ti [7] = '{5'h04, 5'h09, 5'h0C, 5'h03, 5'h02, 5'h17, 5'h05};
    for (int i = 0; i < 7; i++)
      phy_case(LICS_REG_LOW_LANES, sel[i], di[i], ti[i]);
  endtask

  // Low group was left in tap mode, so it must stay there
  task automatic high_group();
    phy_case(LICS_REG_HIGH_LANES, LICS_SEL_INDEX, 5'h07, 5'h09);
    check("low kept", phy_low.drive_base_en, 1'b0);
    check("low tap kept", phy_low.drive_tap, 32'h1 << 3);
  endtask

  task automatic reserved_bits();
    access(1'b1, LICS_REG_LOW_LANES, 32'h9FFF9FFF, rd);
    access(1'b0, LICS_REG_LOW_LANES, 32'h0, rd);
    check("reserved", rd, 32'h801F801F);
    access(1'b1, 10'h0C1, 32'h20012001, rd);
    access(1'b0, 10'h0C1, 32'h0, rd);
    check("unmapped", rd, 32'h00000000);
    access(1'b0, LICS_REG_LOW_LANES, 32'h0, rd);
    check("unmapped wr", rd, 32'h801F801F);
  endtask

  // Without immediate update nothing moves until the link disconnects
  task automatic disconnect_apply();
    @(posedge mclk);
    #1 immediate_update_enable = 1'b0;
    access(1'b1, LICS_REG_LOW_LANES, {3'b001, 8'h00, 5'h12, 3'b001, 8'h00, 5'h11}, rd);
    repeat (150) @(posedge mclk);
    check("held drive", phy_low.drive_code, 5'h00);
    check("held base", phy_low.drive_base_en, 1'b0);
    #1 link_disconnect = 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    check("disc drive", phy_low.drive_code, 5'h11);
    check("disc term", phy_low.term_code, 5'h12);
    link_disconnect = 1'b0;
    immediate_update_enable = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    do_reset(1'b1);
    reset_values(32'h001F001F);
    mode_table();
    high_group();
    reserved_bits();
    phy_case(LICS_REG_LOW_LANES, LICS_SEL_TAP, 5'h03, 5'h05);
    phy_case(LICS_REG_HIGH_LANES, LICS_SEL_TAP, 5'h1D, 5'h02);
    disconnect_apply();
    do_reset(1'b0);
    reset_values(32'h00000000);
    results();
  end
endmodule
